/* hdl/dpt_pkg.sv */
/*
 Package of the debug, performance, trace and watch unit: register
 numbers, field positions, reset values and carrier types.
 Assumes a core register port that addresses registers by number.
*/
`default_nettype none

package dpt_pkg;

  // ----------------------------------------------------------------
  // Register numbers on the core register port
  // ----------------------------------------------------------------
  localparam logic [7:0] DPT_REG_WATCH_CTL0 = 8'h00;
  localparam logic [7:0] DPT_REG_WATCH_STA0 = 8'h04;
  localparam logic [7:0] DPT_REG_WATCH_LOW0 = 8'h08;
  localparam logic [7:0] DPT_REG_WATCH_HIGH0 = 8'h09;
  localparam logic [7:0] DPT_REG_PERF_MASK = 8'h10;
  localparam logic [7:0] DPT_REG_CYCLE_LOW = 8'h11;
  localparam logic [7:0] DPT_REG_CYCLE_HIGH = 8'h12;
  localparam logic [7:0] DPT_REG_PERF_COUNT = 8'h13;
  localparam logic [7:0] DPT_REG_TRACE_INDEX = 8'h14;
  localparam logic [7:0] DPT_REG_TRACE_ENTRY0 = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DPT_SUM_BIT = 31;
  localparam int DPT_EVENT_BITS = 31;
  localparam int DPT_CTL_MODE_LSB = 0;
  localparam int DPT_CTL_COUNT_LSB = 16;
  localparam int DPT_STA_EXEC_LSB = 16;
  localparam int DPT_STA_COUNT_LSB = 0;
  localparam int DPT_COUNT_BITS = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] DPT_MASK_RESET = 32'h0000_0000;
  localparam logic [63:0] DPT_CYCLE_RESET = 64'h0000_0000_0000_0000;
  localparam logic [1:0] DPT_WATCH_DISABLED = 2'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic wide;
    logic priv;
    logic [7:0] num;
    logic [31:0] wdata;
  } dpt_req_s;

  typedef struct packed {
    logic [DPT_EVENT_BITS-1:0] events;
    logic fetch_nonseq;
    logic [31:0] fetch_pc;
  } dpt_core_s;

endpackage

`default_nettype wire

/* hdl/dpt_unit.sv */
/*
 Debug, performance, trace and watch unit of a DSP core.
 Assumes the core presents one register request per cycle on the core
 register port, synchronous to i_ref_clk, acks it the same cycle and gives read data the next.
*/
`timescale 1ns/1ps
`default_nettype none

module dpt_unit
  import dpt_pkg::*;
#(
  parameter int WATCH_COUNT = 3,
  parameter int TRACE_DEPTH = 8
)(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_jtag_rst_n,
  input wire dpt_req_s i_req,
  input wire dpt_core_s i_core,
  input wire logic [WATCH_COUNT-1:0] i_watch_hit,
  output logic [31:0] o_rdata,
  output logic o_ack,
  output logic o_reject
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_q;
  logic jtag_meta_q;
  logic jtag_q;

  // Register numbers and the 3-bit trace index only serve these ranges
  if (WATCH_COUNT < 1 || WATCH_COUNT > 4 || TRACE_DEPTH != 8)
  begin : g_bad_params
    $error("dpt_unit: unsupported parameters");
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_jtag_rst_n)
  begin
    if (!i_jtag_rst_n)
    begin
      jtag_meta_q <= 1'b0;
      jtag_q <= 1'b0;
    end
    else
    begin
      jtag_meta_q <= 1'b1;
      jtag_q <= jtag_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic wide_bad;
  logic wr_ok;
  logic cyc_priv_bad;
  logic hit_cycle;

  // Wide moves are refused whole, never split into halves
  assign wide_bad = i_req.wide && (i_req.rd || i_req.wr);
  assign hit_cycle = (i_req.num == DPT_REG_CYCLE_LOW) ||
                     (i_req.num == DPT_REG_CYCLE_HIGH);
  assign cyc_priv_bad = i_req.wr && hit_cycle && !i_req.priv;
  assign wr_ok = i_req.wr && !wide_bad && !cyc_priv_bad;
  assign o_ack = (i_req.rd || i_req.wr) && !wide_bad && !cyc_priv_bad;
  assign o_reject = wide_bad || cyc_priv_bad;

  // ----------------------------------------------------------------
  // Performance mask and event counter
  // ----------------------------------------------------------------
  logic [31:0] mask_q;
  logic [31:0] perf_q;
  logic [DPT_EVENT_BITS-1:0] picked;
  logic [5:0] picked_sum;

  always_ff @(posedge i_ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      mask_q <= DPT_MASK_RESET;
    end
    else if (wr_ok && i_req.num == DPT_REG_PERF_MASK)
    begin
      mask_q <= i_req.wdata;
    end
  end

  // Bus transfer kinds and unit instruction bits are plain event lines
  assign picked = i_core.events & mask_q[DPT_EVENT_BITS-1:0];

  always_comb
  begin
    picked_sum = 6'h00;
    for (int i = 0; i < DPT_EVENT_BITS; i++)
    begin
      picked_sum = picked_sum + {5'h00, picked[i]};
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      perf_q <= 32'h0000_0000;
    end
    else if (wr_ok && i_req.num == DPT_REG_PERF_COUNT)
    begin
      perf_q <= i_req.wdata;
    end
    else if (mask_q[DPT_SUM_BIT])
    begin
      perf_q <= perf_q + 32'(picked_sum);
    end
    else if (|picked)
    begin
      perf_q <= perf_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Cycle counter
  // ----------------------------------------------------------------
  logic [63:0] cycle_q;

  // Only the test access port reset clears it
  always_ff @(posedge i_ref_clk or negedge jtag_q)
  begin
    if (!jtag_q)
    begin
      cycle_q <= DPT_CYCLE_RESET;
    end
    else if (wr_ok && i_req.num == DPT_REG_CYCLE_LOW)
    begin
      cycle_q <= {cycle_q[63:32], i_req.wdata};
    end
    else if (wr_ok && i_req.num == DPT_REG_CYCLE_HIGH)
    begin
      cycle_q <= {i_req.wdata, cycle_q[31:0]};
    end
    else
    begin
      cycle_q <= cycle_q + 64'h0000_0000_0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Watchpoints
  // ----------------------------------------------------------------
  logic [31:0] wctl_q [WATCH_COUNT];
  logic [1:0] wexec_q [WATCH_COUNT];
  logic [DPT_COUNT_BITS-1:0] wcnt_q [WATCH_COUNT];
  logic [31:0] wlow_q [WATCH_COUNT];
  logic [31:0] whigh_q [WATCH_COUNT];

  for (genvar w = 0; w < WATCH_COUNT; w++)
  begin : g_watch
    localparam logic [7:0] W8 = 8'(w);
    localparam logic [7:0] W2 = 8'(2 * w);
    logic ctl_wr;

    assign ctl_wr = wr_ok && i_req.num == DPT_REG_WATCH_CTL0 + W8;

    always_ff @(posedge i_ref_clk or negedge rst_q)
    begin
      if (!rst_q)
      begin
        wctl_q[w] <= 32'h0000_0000;
      end
      else if (ctl_wr)
      begin
        wctl_q[w] <= i_req.wdata;
      end
    end

    always_ff @(posedge i_ref_clk or negedge rst_q)
    begin
      if (!rst_q)
      begin
        wexec_q[w] <= DPT_WATCH_DISABLED;
        wcnt_q[w] <= '0;
      end
      else if (ctl_wr)
      begin
        wexec_q[w] <= i_req.wdata[DPT_CTL_MODE_LSB +: 2];
        wcnt_q[w] <= i_req.wdata[DPT_CTL_COUNT_LSB +: DPT_COUNT_BITS];
      end
      else if (wexec_q[w] != DPT_WATCH_DISABLED && i_watch_hit[w] &&
               wcnt_q[w] != '0)
      begin
        // Counter stops at zero rather than wrapping
        wcnt_q[w] <= wcnt_q[w] - 16'h0001;
      end
    end

    // Pointers left without reset to save reset fan-out
    always_ff @(posedge i_ref_clk)
    begin
      if (wr_ok && i_req.num == DPT_REG_WATCH_LOW0 + W2)
      begin
        wlow_q[w] <= i_req.wdata;
      end
      if (wr_ok && i_req.num == DPT_REG_WATCH_HIGH0 + W2)
      begin
        whigh_q[w] <= i_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trace buffer
  // ----------------------------------------------------------------
  logic [31:0] trace_q [TRACE_DEPTH];
  logic [2:0] tidx_q;
  logic tfirst_q;
  logic [2:0] tnext;

  // First fetch lands in entry zero, later ones step on
  assign tnext = tfirst_q ? 3'h0 : tidx_q + 3'h1;

  // No software write path exists here
  always_ff @(posedge i_ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      tidx_q <= 3'h0;
      tfirst_q <= 1'b1;
      for (int i = 0; i < TRACE_DEPTH; i++)
      begin
        trace_q[i] <= 32'h0000_0000;
      end
    end
    else if (i_core.fetch_nonseq)
    begin
      trace_q[tnext] <= i_core.fetch_pc;
      tidx_q <= tnext;
      tfirst_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_d;
  logic [31:0] rdata_q;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (i_req.num)
      DPT_REG_PERF_MASK: rd_d = mask_q;
      DPT_REG_PERF_COUNT: rd_d = perf_q;
      DPT_REG_CYCLE_LOW: rd_d = cycle_q[31:0];
      DPT_REG_CYCLE_HIGH: rd_d = cycle_q[63:32];
      DPT_REG_TRACE_INDEX: rd_d = 32'(tidx_q);
      default: rd_d = 32'h0000_0000;
    endcase
    for (int i = 0; i < TRACE_DEPTH; i++)
    begin
      if (i_req.num == DPT_REG_TRACE_ENTRY0 + 8'(i))
      begin
        rd_d = trace_q[i];
      end
    end
    for (int w = 0; w < WATCH_COUNT; w++)
    begin
      if (i_req.num == DPT_REG_WATCH_CTL0 + 8'(w))
      begin
        rd_d = wctl_q[w];
      end
      if (i_req.num == DPT_REG_WATCH_STA0 + 8'(w))
      begin
        rd_d = '0;
        rd_d[DPT_STA_EXEC_LSB +: 2] = wexec_q[w];
        rd_d[DPT_STA_COUNT_LSB +: DPT_COUNT_BITS] = wcnt_q[w];
      end
      if (i_req.num == DPT_REG_WATCH_LOW0 + 8'(2 * w))
      begin
        rd_d = wlow_q[w];
      end
      if (i_req.num == DPT_REG_WATCH_HIGH0 + 8'(2 * w))
      begin
        rd_d = whigh_q[w];
      end
    end
  end

  // Reads of the cycle counter are open in every mode
  always_ff @(posedge i_ref_clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (i_req.rd && o_ack)
    begin
      rdata_q <= rd_d;
    end
  end

  assign o_rdata = rdata_q;

endmodule

`default_nettype wire

/* tb/dpt_unit_monitor.sv */
/*
 Checker of the debug unit's core register port.
 Assumes it is bound to dpt_unit and sees that module's ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module dpt_unit_monitor
  import dpt_pkg::*;
#(
  parameter int WATCH_COUNT = 3,
  parameter int TRACE_DEPTH = 8
)(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_jtag_rst_n,
  input wire dpt_req_s i_req,
  input wire dpt_core_s i_core,
  input wire logic [WATCH_COUNT-1:0] i_watch_hit,
  input wire logic [31:0] o_rdata,
  input wire logic o_ack,
  input wire logic o_reject
);
  // --------------------------------------------------------------
  // Port relations
  // --------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic acc = i_req.rd | i_req.wr;
  wire logic cyc = (i_req.num == DPT_REG_CYCLE_LOW) ||
    (i_req.num == DPT_REG_CYCLE_HIGH);
  wire logic [17:0] sta = {i_req.wdata[1:0], i_req.wdata[31:16]};
  property p_wide;
    acc && i_req.wide |-> o_reject && !o_ack;
  endproperty
  a_wide: assert property (p_wide) else $error("wide taken");
  property p_priv;
    i_req.wr && !i_req.priv && cyc |-> o_reject && !o_ack;
  endproperty
  a_priv: assert property (p_priv) else $error("cycle write");
  property p_ack;
    acc && !i_req.wide && !(i_req.wr && cyc && !i_req.priv) |-> o_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_hold;
    !(o_ack && i_req.rd) |=> $stable(o_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_mask;
    i_req.wr && o_ack && i_req.num == DPT_REG_PERF_MASK ##1
    i_req.rd && o_ack && i_req.num == DPT_REG_PERF_MASK
    |=> o_rdata == $past(i_req.wdata, 2);
  endproperty
  a_mask: assert property (p_mask) else $error("mask lost");
  property p_index;
    i_req.rd && o_ack && i_req.num == DPT_REG_TRACE_INDEX
    |=> o_rdata < 32'h0000_0008;
  endproperty
  a_index: assert property (p_index) else $error("index wide");
  property p_run;
    (i_req.rd && o_ack && i_req.num == DPT_REG_CYCLE_LOW &&
    i_jtag_rst_n) [*2] |=> o_rdata == $past(o_rdata) + 32'h0000_0001;
  endproperty
  a_run: assert property (p_run) else $error("cycle stuck");
  property p_watch;
    i_req.wr && o_ack && i_req.num == DPT_REG_WATCH_CTL0 &&
    !i_watch_hit[0] ##1 i_req.rd && i_req.num == DPT_REG_WATCH_STA0 &&
    !i_watch_hit[0] |=> o_rdata[17:0] == $past(sta, 2);
  endproperty
  a_watch: assert property (p_watch) else $error("watch load");
endmodule
bind dpt_unit dpt_unit_monitor #(
  .WATCH_COUNT(WATCH_COUNT),
  .TRACE_DEPTH(TRACE_DEPTH)
) dpt_unit_monitor_inst (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_jtag_rst_n(i_jtag_rst_n), .i_req(i_req), .i_core(i_core),
  .i_watch_hit(i_watch_hit), .o_rdata(o_rdata), .o_ack(o_ack),
  .o_reject(o_reject)
);
`default_nettype wire

/* tb/dpt_unit_tb.sv */
/*
 Self-checking bench of the debug unit.
 Assumes dpt_pkg, dpt_unit and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end
module dpt_unit_tb import dpt_pkg::*;;
  logic clk;
  logic rst_n;
  logic jrst_n;
  dpt_req_s req;
  dpt_core_s core;
  logic [2:0] hit;
  logic [31:0] rdata;
  logic ack;
  logic rej;
  logic [31:0] rd_v;
  logic ack_v;
  logic rej_v;
  int fail_count;
  int tests_run;
  dpt_unit dpt_unit_inst (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_jtag_rst_n(jrst_n),
    .i_req(req), .i_core(core), .i_watch_hit(hit),
    .o_rdata(rdata), .o_ack(ack), .o_reject(rej)
  );
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // --------------------------------------------------------------
  // Port tasks, entered and left at a falling edge
  // --------------------------------------------------------------
  task automatic acc(input logic r, w, wd, pv, input logic [7:0] n,
    input logic [31:0] d);
    req = '{r, w, wd, pv, n, d};
    #1;
    ack_v = ack;
    rej_v = rej;
    @(negedge clk);
    rd_v = rdata;
  endtask
  task automatic wr(input logic [7:0] n, input logic [31:0] d);
    acc(1'b0, 1'b1, 1'b0, 1'b1, n, d);
  endtask
  task automatic rd(input logic [7:0] n);
    acc(1'b1, 1'b0, 1'b0, 1'b0, n, 32'h0000_0000);
  endtask
  task automatic t_reset;
    rd(DPT_REG_PERF_MASK);
    `CHK("mask", 32'h0000_0000, rd_v)
    rd(DPT_REG_WATCH_STA0);
    `CHK("exec", 2'h0, rd_v[17:16])
    rd(DPT_REG_WATCH_CTL0);
    `CHK("mode", 2'h0, rd_v[1:0])
    rd(DPT_REG_PERF_COUNT);
    `CHK("perf", 32'h0000_0000, rd_v)
    for (int i = 0; i < 9; i++)
    begin
      rd(i < 8 ? DPT_REG_TRACE_ENTRY0 + 8'(i) : DPT_REG_TRACE_INDEX);
      `CHK("trace", 32'h0000_0000, rd_v)
    end
  endtask
  // Two cycles of events, so a sum shows as twice the popcount
  task automatic t_perf(input logic [31:0] m, input logic [30:0] ev,
    input logic [31:0] x);
    wr(DPT_REG_PERF_MASK, m);
    rd(DPT_REG_PERF_MASK);
    `CHK("mask", m, rd_v)
    wr(DPT_REG_PERF_COUNT, 32'h0000_0000);
    req = '0;
    core.events = ev;
    repeat (2) @(negedge clk);
    core.events = '0;
    rd(DPT_REG_PERF_COUNT);
    `CHK("count", x, rd_v)
  endtask
  task automatic t_cycle;
    wr(DPT_REG_CYCLE_HIGH, 32'h0000_0005);
    acc(1'b0, 1'b1, 1'b0, 1'b0, DPT_REG_CYCLE_HIGH, 32'h0000_0077);
    `CHK("rej", 1'b1, rej_v)
    wr(DPT_REG_CYCLE_LOW, 32'hFFFF_FFFE);
    rd(DPT_REG_CYCLE_LOW);
    rd(DPT_REG_CYCLE_LOW);
    rd(DPT_REG_CYCLE_HIGH);
    `CHK("carry", 32'h0000_0006, rd_v)
    acc(1'b1, 1'b0, 1'b1, 1'b1, DPT_REG_CYCLE_LOW, 32'h0000_0000);
    `CHK("wide", 2'b01, {ack_v, rej_v})
    jrst_n = 1'b0;
    @(negedge clk);
    jrst_n = 1'b1;
    repeat (3) @(negedge clk);
    rd(DPT_REG_CYCLE_HIGH);
    `CHK("tap", 32'h0000_0000, rd_v)
  endtask
  // Nine fetches back to back: the ninth wraps to entry zero
  task automatic t_trace;
    for (int i = 0; i < 9; i++)
    begin
      core.fetch_nonseq = 1'b1;
      core.fetch_pc = 32'h1000_0000 + 32'(i);
      @(negedge clk);
    end
    core.fetch_nonseq = 1'b0;
    wr(DPT_REG_TRACE_ENTRY0, 32'h0000_BEEF);
    rd(DPT_REG_TRACE_INDEX);
    `CHK("index", 32'h0000_0000, rd_v)
    for (int i = 0; i < 8; i++)
    begin
      rd(DPT_REG_TRACE_ENTRY0 + 8'(i));
      `CHK("entry", 32'h1000_0000 + 32'(i == 0 ? 8 : i), rd_v)
    end
  endtask
  task automatic t_watch;
    for (int k = 0; k < 3; k++)
    begin
      wr(DPT_REG_WATCH_CTL0 + 8'(k), 32'h0005_0001);
      rd(DPT_REG_WATCH_STA0 + 8'(k));
      `CHK("load", 18'h1_0005, rd_v[17:0])
      wr(DPT_REG_WATCH_LOW0 + 8'(2 * k), 32'h1234_0000 + 32'(k));
      wr(DPT_REG_WATCH_HIGH0 + 8'(2 * k), 32'h4321_0000 + 32'(k));
      rd(DPT_REG_WATCH_LOW0 + 8'(2 * k));
      `CHK("low", 32'h1234_0000 + 32'(k), rd_v)
      rd(DPT_REG_WATCH_HIGH0 + 8'(2 * k));
      `CHK("high", 32'h4321_0000 + 32'(k), rd_v)
    end
    req = '0;
    hit = 3'b111;
    repeat (2) @(negedge clk);
    hit = 3'b000;
    for (int k = 0; k < 3; k++)
    begin
      rd(DPT_REG_WATCH_STA0 + 8'(k));
      `CHK("hits", 16'h0003, rd_v[15:0])
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #200000;
    fail_count++;
    results();
  end
  initial
  begin
    fail_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    jrst_n = 1'b0;
    req = '0;
    core = '0;
    hit = 3'b000;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    jrst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_perf(32'h83E0_0000, 31'h0160_0000, 32'h0000_0006);
    t_perf(32'h03E0_0000, 31'h0160_0000, 32'h0000_0002);
    t_perf(32'h801C_0000, 31'h001C_0020, 32'h0000_0006);
    t_perf(32'h0000_0000, 31'h7FFF_FFFF, 32'h0000_0000);
    t_cycle();
    t_trace();
    t_watch();
    results();
  end
endmodule
`default_nettype wire
